// *** hw/csi_pkg.sv ***
// Shared constants and types for the processor system and init interface
package csi_pkg;

	// ****************************************
	// Bus widths
	// ****************************************
	localparam int AD_W = 64;       // Address/data bus width
	localparam int ADC_W = 8;       // Check bus width, one bit per byte
	localparam int CMD_W = 9;       // Command/identifier bus width
	localparam int INT_W = 6;       // General interrupt inputs
	localparam int IRQ_W = 7;       // Interrupt register bits driven here
	localparam int NMI_BIT = 6;     // Non-maskable position
	localparam int TIMER_BIT = 5;   // Timer interrupt shares this position

	// ****************************************
	// Clock ratios
	// ****************************************
	localparam int SYS_DIV = 2;     // Core cycles per system clock
	localparam int MODE_DIV = 256;  // System clocks per boot-mode clock
	localparam int MODE_PERIOD = MODE_DIV * SYS_DIV;
	localparam int MODE_HALF = MODE_PERIOD / 2;
	localparam int MODE_CNT_W = $clog2(MODE_PERIOD);
	localparam int MODE_BITS = 256; // Boot-mode stream length

	// ****************************************
	// Boot-mode stream field positions
	// ****************************************
	localparam int WB_LSB = 1;
	localparam int WB_W = 4;
	localparam int DIV_LSB = 5;
	localparam int DIV_W = 3;
	localparam int ENDIAN_BIT = 8;
	localparam int WMODE_LSB = 9;
	localparam int WMODE_W = 2;
	localparam int TIMER_DIS_BIT = 11;
	localparam int DRIVE_LSB = 13;
	localparam int DRIVE_W = 2;
	localparam int TCLK_DIS_LSB = 15;
	localparam int RCLK_DIS_LSB = 17;
	localparam int CLK_PAIR_W = 2;
	localparam int MODE_USED = 19;  // Bits at and above are zero

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [AD_W-1:0] ad;        // Address or data word
		logic [ADC_W-1:0] check;    // Parity bits
		logic [CMD_W-1:0] cmd;      // Command or data identifier
	} csi_word_t;

	typedef struct packed {
		logic [WB_W-1:0] wb_rate;   // Writeback data pattern
		logic [DIV_W-1:0] clk_div;  // Clock divisor code
		logic big_endian;           // Byte order
		logic [WMODE_W-1:0] write_mode;
		logic timer_dis;            // Timer interrupt disabled
		logic [DRIVE_W-1:0] drive;  // Output drive strength
		logic [CLK_PAIR_W-1:0] tclk_dis;
		logic [CLK_PAIR_W-1:0] rclk_dis;
	} csi_boot_cfg_t;

	typedef struct packed {
		logic primary_clk;
		logic cold_n;
		logic reset_n;
		logic power_good;
		logic mode_data;
		logic [INT_W-1:0] int_n;
		logic nmi_n;
		logic ext_req_n;
		logic read_acc_n;
		logic write_acc_n;
		logic agent_valid_n;
		csi_word_t word;
	} csi_pin_t;

	// ****************************************
	// Reset values
	// ****************************************
	localparam csi_pin_t PIN_RST = '{primary_clk: 1'h0, cold_n: 1'h0,
		reset_n: 1'h0, power_good: 1'h0, mode_data: 1'h0, int_n: '1,
		nmi_n: 1'h1, ext_req_n: 1'h1, read_acc_n: 1'h1, write_acc_n: 1'h1,
		agent_valid_n: 1'h1, word: '0};
	localparam csi_boot_cfg_t BOOT_CFG_RST = '0;

	// ****************************************
	// State encodings
	// ****************************************
	typedef enum logic [1:0] {
		BUS_MASTER = 2'h0,
		BUS_RELEASE = 2'h1,
		BUS_SLAVE = 2'h2
	} csi_bus_state_t;

	typedef enum logic [1:0] {
		BOOT_IDLE = 2'h0,
		BOOT_LOAD = 2'h1,
		BOOT_DONE = 2'h2
	} csi_boot_state_t;

endpackage

// *** hw/csi_top.sv ***
// Processor pin-level system bus, clock, interrupt and boot-mode logic

// What this block does
// - Starred signals are asserted when driven low
// - Release output marks handover into slave state
// - Processor valid strobe marks processor-driven words
// - One shared 64-bit address/data bus
// - Eight check bits carry byte parity
// - Nine-bit command bus in both directions
// - Command parity ignored in, zero out
// - Core twice system rate; master clock echoed
// - Two transmit, two receive clocks at system rate
// - Reserved output and fault output stay high
// - General interrupts ORed into bits 5:0
// - Non-maskable interrupt ORed into bit 6
// - Power-good rise starts boot stream reading
// - System, transmit and receive clocks start at cold reset negation
// - Boot clock is system clock over 256
// - Boot stream is 256 bits of fields
module csi_top #(
	parameter int MODE_LEN = csi_pkg::MODE_BITS // Boot stream length
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// Clock, reset and init pins
	input wire logic primary_clock_in,
	input wire logic cold_reset_n_in,
	input wire logic reset_n_in,
	input wire logic power_good_in,
	input wire logic boot_mode_data_in,
	output logic primary_clock_out,
	output logic system_clock_out,
	output logic sync_loop_out,
	output logic [csi_pkg::CLK_PAIR_W-1:0] transmit_clock_out,
	output logic [csi_pkg::CLK_PAIR_W-1:0] receive_clock_out,
	output logic boot_mode_clock_out,
	output logic reserved_future_output_out,
	output logic fault_n_out,
	// Interrupt pins
	input wire logic [csi_pkg::INT_W-1:0] int_n_in,
	input wire logic nmi_n_in,
	// System interface pins
	input wire logic ext_request_n_in,
	input wire logic read_accept_n_in,
	input wire logic write_accept_n_in,
	input wire logic agent_valid_n_in,
	output logic release_n_out,
	output logic cpu_valid_n_out,
	input wire logic [csi_pkg::AD_W-1:0] addr_data_bus_in,
	output logic [csi_pkg::AD_W-1:0] addr_data_bus_out,
	output logic addr_data_bus_oe_out,
	input wire logic [csi_pkg::ADC_W-1:0] addr_data_check_bus_in,
	output logic [csi_pkg::ADC_W-1:0] addr_data_check_bus_out,
	output logic addr_data_check_bus_oe_out,
	input wire logic [csi_pkg::CMD_W-1:0] command_id_bus_in,
	output logic [csi_pkg::CMD_W-1:0] command_id_bus_out,
	output logic command_id_bus_oe_out,
	input wire logic command_parity_bit_in,
	output logic command_parity_bit_out,
	output logic command_parity_bit_oe_out,
	// Core side: outgoing words
	input wire logic tx_valid_in,
	input wire logic tx_is_read_in,
	input wire logic tx_is_write_in,
	input wire csi_pkg::csi_word_t tx_word_in,
	output logic tx_ready_out,
	// Core side: bus ownership and incoming words
	input wire logic release_req_in,
	input wire logic reclaim_in,
	output logic ext_request_out,
	output logic rx_valid_out,
	output csi_pkg::csi_word_t rx_word_out,
	// Core side: interrupts, reset and boot configuration
	input wire logic timer_irq_in,
	output logic [csi_pkg::IRQ_W-1:0] irq_out,
	output logic core_reset_out,
	output logic boot_done_out,
	output csi_pkg::csi_boot_cfg_t boot_cfg_out
);

	// ****************************************
	// Elaboration checks
	// ****************************************
	localparam int IDX_W = $clog2(MODE_LEN);
	generate
		if (MODE_LEN < csi_pkg::MODE_USED || MODE_LEN > csi_pkg::MODE_BITS) begin : g_bad_len
			$error("boot stream length out of range");
		end
	endgenerate

	// ****************************************
	// Pin synchronisers
	// ****************************************
	csi_pkg::csi_pin_t pin_raw; // Gathered pin inputs
	csi_pkg::csi_pin_t pin_m_r; // First stage, read only by second
	csi_pkg::csi_pin_t pin_s_r; // Second stage, safe to use
	assign pin_raw = '{primary_clk: primary_clock_in, cold_n: cold_reset_n_in,
		reset_n: reset_n_in, power_good: power_good_in,
		mode_data: boot_mode_data_in, int_n: int_n_in, nmi_n: nmi_n_in,
		ext_req_n: ext_request_n_in, read_acc_n: read_accept_n_in,
		write_acc_n: write_accept_n_in, agent_valid_n: agent_valid_n_in,
		word: '{ad: addr_data_bus_in, check: addr_data_check_bus_in,
		cmd: command_id_bus_in}};

	// Two flops per pin; command parity input is never looked at
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			pin_m_r <= csi_pkg::PIN_RST;
			pin_s_r <= csi_pkg::PIN_RST;
		end else begin
			pin_m_r <= pin_raw;
			pin_s_r <= pin_m_r;
		end
	end

	// ****************************************
	// Clock outputs and reset
	// ****************************************
	logic sys_clk_r, sys_clk_nxt;       // System interface clock
	logic pclk_r, pclk_nxt;             // Echo of master clock
	logic [1:0] tclk_r, tclk_nxt;       // Transmit clocks
	logic [1:0] rclk_r, rclk_nxt;       // Receive clocks
	logic core_rst_r, core_rst_nxt;     // Cold or warm reset active
	csi_pkg::csi_boot_cfg_t cfg_r, cfg_nxt;

	// System, transmit and receive clocks hold low in cold reset and start on its negation; the master echo keeps running
	always_comb begin
		pclk_nxt = pin_s_r.primary_clk;
		core_rst_nxt = !pin_s_r.cold_n || !pin_s_r.reset_n;
		if (!pin_s_r.cold_n) begin
			sys_clk_nxt = 1'h0;
		end else begin
			sys_clk_nxt = !sys_clk_r; // Half the core rate
		end
		// Each pair copies the system clock unless disabled
		tclk_nxt = {2{sys_clk_nxt}} & ~cfg_r.tclk_dis;
		rclk_nxt = {2{sys_clk_nxt}} & ~cfg_r.rclk_dis;
	end

	// Registers for the clock outputs
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			sys_clk_r <= 1'h0;
			pclk_r <= 1'h0;
			tclk_r <= 2'h0;
			rclk_r <= 2'h0;
			core_rst_r <= 1'h1;
		end else begin
			sys_clk_r <= sys_clk_nxt;
			pclk_r <= pclk_nxt;
			tclk_r <= tclk_nxt;
			rclk_r <= rclk_nxt;
			core_rst_r <= core_rst_nxt;
		end
	end

	assign primary_clock_out = pclk_r;
	assign system_clock_out = sys_clk_r;
	assign sync_loop_out = sys_clk_r;
	assign transmit_clock_out = tclk_r;
	assign receive_clock_out = rclk_r;
	assign core_reset_out = core_rst_r;
	assign reserved_future_output_out = 1'h1;
	assign fault_n_out = 1'h1;

	// ****************************************
	// Interrupt register bits
	// ****************************************
	logic [csi_pkg::IRQ_W-1:0] irq_r, irq_nxt;

	// Low-active pins inverted and ORed in bit for bit
	always_comb begin
		irq_nxt = '0;
		irq_nxt[csi_pkg::INT_W-1:0] = ~pin_s_r.int_n;
		irq_nxt[csi_pkg::TIMER_BIT] = irq_nxt[csi_pkg::TIMER_BIT] ||
			(timer_irq_in && !cfg_r.timer_dis);
		irq_nxt[csi_pkg::NMI_BIT] = !pin_s_r.nmi_n;
	end

	// Register the interrupt bits
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			irq_r <= '0;
		end else begin
			irq_r <= irq_nxt;
		end
	end
	assign irq_out = irq_r;

	// ****************************************
	// Boot-mode serial stream
	// ****************************************
	csi_pkg::csi_boot_state_t boot_st_r, boot_st_nxt;
	logic [csi_pkg::MODE_CNT_W-1:0] mcnt_r, mcnt_nxt;  // Core cycles in period
	logic [IDX_W-1:0] bidx_r, bidx_nxt;                // Bit being received
	logic [MODE_LEN-1:0] msh_r, msh_nxt;               // Stream shifter
	logic pg_d_r;                                      // Power-good delayed
	logic mclk_r, mclk_nxt;                            // Boot clock pin
	logic sample;                                      // Rising boot clock

	assign sample = (mcnt_r == csi_pkg::MODE_CNT_W'(csi_pkg::MODE_HALF - 1));

	// Walk the stream one bit per boot clock, bit 0 first
	always_comb begin
		boot_st_nxt = boot_st_r;
		mcnt_nxt = mcnt_r + 1'b1;
		bidx_nxt = bidx_r;
		msh_nxt = msh_r;
		cfg_nxt = cfg_r;
		case (boot_st_r)
			csi_pkg::BOOT_IDLE: begin
				mcnt_nxt = '0;
				bidx_nxt = '0;
				if (pin_s_r.power_good && !pg_d_r) begin
					boot_st_nxt = csi_pkg::BOOT_LOAD;
				end
			end
			csi_pkg::BOOT_LOAD: begin
				if (sample) begin
					// One sample per period
					msh_nxt = {pin_s_r.mode_data, msh_r[MODE_LEN-1:1]};
					bidx_nxt = bidx_r + 1'b1;
					if (bidx_r == IDX_W'(MODE_LEN - 1)) begin
						boot_st_nxt = csi_pkg::BOOT_DONE;
						// Decode the documented fields
						cfg_nxt.wb_rate = msh_nxt[csi_pkg::WB_LSB +: csi_pkg::WB_W];
						cfg_nxt.clk_div = msh_nxt[csi_pkg::DIV_LSB +: csi_pkg::DIV_W];
						cfg_nxt.big_endian = msh_nxt[csi_pkg::ENDIAN_BIT];
						cfg_nxt.write_mode =
							msh_nxt[csi_pkg::WMODE_LSB +: csi_pkg::WMODE_W];
						cfg_nxt.timer_dis = msh_nxt[csi_pkg::TIMER_DIS_BIT];
						cfg_nxt.drive = msh_nxt[csi_pkg::DRIVE_LSB +: csi_pkg::DRIVE_W];
						cfg_nxt.tclk_dis =
							msh_nxt[csi_pkg::TCLK_DIS_LSB +: csi_pkg::CLK_PAIR_W];
						cfg_nxt.rclk_dis =
							msh_nxt[csi_pkg::RCLK_DIS_LSB +: csi_pkg::CLK_PAIR_W];
					end
				end
			end
			csi_pkg::BOOT_DONE: begin
				mcnt_nxt = '0;
			end
			default: begin
				boot_st_nxt = csi_pkg::BOOT_IDLE;
			end
		endcase
		// Losing power-good abandons the stream
		if (!pin_s_r.power_good) begin
			boot_st_nxt = csi_pkg::BOOT_IDLE;
		end
		// Boot clock is high in the second half of each period
		mclk_nxt = (boot_st_nxt == csi_pkg::BOOT_LOAD) &&
			mcnt_nxt[csi_pkg::MODE_CNT_W-1];
	end

	// Register the boot stream state
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			boot_st_r <= csi_pkg::BOOT_IDLE;
			mcnt_r <= '0;
			bidx_r <= '0;
			msh_r <= '0;
			pg_d_r <= 1'h0;
			mclk_r <= 1'h0;
			cfg_r <= csi_pkg::BOOT_CFG_RST;
		end else begin
			boot_st_r <= boot_st_nxt;
			mcnt_r <= mcnt_nxt;
			bidx_r <= bidx_nxt;
			msh_r <= msh_nxt;
			pg_d_r <= pin_s_r.power_good;
			mclk_r <= mclk_nxt;
			cfg_r <= cfg_nxt;
		end
	end
	assign boot_mode_clock_out = mclk_r;
	assign boot_done_out = (boot_st_r == csi_pkg::BOOT_DONE);
	assign boot_cfg_out = cfg_r;

	// ****************************************
	// System interface ownership and strobes
	// ****************************************
	csi_pkg::csi_bus_state_t bus_st_r, bus_st_nxt;
	csi_pkg::csi_word_t tx_r, tx_nxt;     // Word on the shared buses
	csi_pkg::csi_word_t rx_r, rx_nxt;     // Last word from the agent
	logic vout_n_r, vout_n_nxt;           // Processor valid strobe
	logic rel_n_r, rel_n_nxt;             // Release strobe
	logic oe_r, oe_nxt;                   // Processor drives the buses
	logic rxv_r, rxv_nxt;                 // Word received pulse
	logic [csi_pkg::ADC_W-1:0] par;       // Parity of the outgoing word
	logic tx_ok;                          // Agent can take this word
	logic tx_fire;                        // Word accepted this cycle

	// Even parity per byte of the address/data word
	genvar gi;
	generate
		for (gi = 0; gi < csi_pkg::ADC_W; gi++) begin : g_par
			assign par[gi] = ^tx_word_in.ad[gi*8 +: 8];
		end
	endgenerate

	// Reads wait for read-ready, writes for write-ready
	assign tx_ok = (!tx_is_read_in || !pin_s_r.read_acc_n) &&
		(!tx_is_write_in || !pin_s_r.write_acc_n);
	assign tx_ready_out = (bus_st_r == csi_pkg::BUS_MASTER) && !core_rst_r &&
		!release_req_in && tx_ok;
	assign tx_fire = tx_valid_in && tx_ready_out;

	// Master drives words, hands over on request, listens as slave
	always_comb begin
		bus_st_nxt = bus_st_r;
		tx_nxt = tx_r;
		rx_nxt = rx_r;
		vout_n_nxt = 1'h1;
		rel_n_nxt = 1'h1;
		oe_nxt = oe_r;
		rxv_nxt = 1'h0;
		case (bus_st_r)
			csi_pkg::BUS_MASTER: begin
				oe_nxt = 1'h1;
				if (release_req_in) begin
					bus_st_nxt = csi_pkg::BUS_RELEASE;
					rel_n_nxt = 1'h0;
					oe_nxt = 1'h0;
				end else if (tx_fire) begin
					// Strobe only with a fresh word
					tx_nxt = tx_word_in;
					tx_nxt.check = par;
					vout_n_nxt = 1'h0;
				end
			end
			csi_pkg::BUS_RELEASE: begin
				bus_st_nxt = csi_pkg::BUS_SLAVE;
				oe_nxt = 1'h0;
			end
			csi_pkg::BUS_SLAVE: begin
				oe_nxt = 1'h0;
				if (!pin_s_r.agent_valid_n) begin
					rx_nxt = pin_s_r.word;
					rxv_nxt = 1'h1;
				end
				if (reclaim_in) begin
					bus_st_nxt = csi_pkg::BUS_MASTER;
				end
			end
			default: begin
				bus_st_nxt = csi_pkg::BUS_MASTER;
			end
		endcase
		if (core_rst_r) begin
			bus_st_nxt = csi_pkg::BUS_MASTER;
			vout_n_nxt = 1'h1;
			rel_n_nxt = 1'h1;
		end
	end

	// Register the bus state and pin drivers
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			bus_st_r <= csi_pkg::BUS_MASTER;
			tx_r <= '0;
			rx_r <= '0;
			vout_n_r <= 1'h1;
			rel_n_r <= 1'h1;
			oe_r <= 1'h0;
			rxv_r <= 1'h0;
		end else begin
			bus_st_r <= bus_st_nxt;
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			vout_n_r <= vout_n_nxt;
			rel_n_r <= rel_n_nxt;
			oe_r <= oe_nxt;
			rxv_r <= rxv_nxt;
		end
	end

	assign addr_data_bus_out = tx_r.ad;
	assign addr_data_check_bus_out = tx_r.check;
	assign command_id_bus_out = tx_r.cmd;
	assign command_parity_bit_out = 1'h0;
	assign addr_data_bus_oe_out = oe_r;
	assign addr_data_check_bus_oe_out = oe_r;
	assign command_id_bus_oe_out = oe_r;
	assign command_parity_bit_oe_out = oe_r;
	assign cpu_valid_n_out = vout_n_r;
	assign release_n_out = rel_n_r;
	assign ext_request_out = !pin_s_r.ext_req_n;
	assign rx_valid_out = rxv_r;
	assign rx_word_out = rx_r;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	sequence s_boot_rise;
		boot_st_r == csi_pkg::BOOT_IDLE && pin_s_r.power_good && !pg_d_r;
	endsequence

	sequence s_release;
		bus_st_r == csi_pkg::BUS_MASTER && release_req_in && !core_rst_r;
	endsequence

	a_valid_word: assert property (tx_fire && !release_req_in && !core_rst_r |=>
		!cpu_valid_n_out && addr_data_bus_out == $past(tx_word_in.ad))
		else $error("valid strobe missing after accepted word");
	a_valid_cause: assert property (!cpu_valid_n_out |-> $past(tx_fire))
		else $error("valid strobe without accepted word");
	a_read_gate: assert property (tx_ready_out && tx_is_read_in |->
		!pin_s_r.read_acc_n)
		else $error("read offered without read-ready");
	a_release_slave: assert property (s_release |=> !release_n_out &&
		!addr_data_bus_oe_out ##1 bus_st_r == csi_pkg::BUS_SLAVE && release_n_out)
		else $error("release handover sequence wrong");
	a_cmd_par_zero: assert property (command_parity_bit_out == 1'h0)
		else $error("command parity not zero");
	a_fixed_high: assert property (reserved_future_output_out && fault_n_out)
		else $error("fixed outputs not high");
	a_nmi_bit: assert property (irq_out[csi_pkg::NMI_BIT] ==
		!$past(pin_s_r.nmi_n))
		else $error("nmi bit does not follow pin");
	a_int_bits: assert property ((irq_out[csi_pkg::INT_W-2:0] ==
		~$past(pin_s_r.int_n[csi_pkg::INT_W-2:0])))
		else $error("interrupt bits do not follow pins");
	a_check_par: assert property (!cpu_valid_n_out |->
		addr_data_check_bus_out[0] == ^addr_data_bus_out[7:0])
		else $error("check bit wrong");
	a_boot_start: assert property (s_boot_rise |=>
		boot_st_r == csi_pkg::BOOT_LOAD)
		else $error("boot stream did not start");
	a_clk_hold: assert property (!pin_s_r.cold_n |=> !system_clock_out)
		else $error("system clock runs in cold reset");
	a_clk_toggle: assert property (pin_s_r.cold_n |=>
		system_clock_out != $past(system_clock_out))
		else $error("system clock not at half rate");

endmodule

// *** verif/csi_agent.sv ***
// Far-side model that serves the boot-mode stream
module csi_agent (
	// Clock
	input wire logic clk_in,
	// Boot stream
	input wire logic power_good_in,
	input wire logic boot_mode_clock_in,
	input wire logic [31:0] stream_in,
	output logic boot_mode_data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int idx = 0; // Bit now presented
	logic mclk_q = 1'b0; // Mode clock one cycle ago
	// Step to the next bit after each mode clock fall, bit 0 first
	// Falling edge keeps the model off the edge that launches the clock
	always @(negedge clk_in) begin
		mclk_q <= boot_mode_clock_in;
		if (!power_good_in)
			idx <= 0; // Stream restarts with power-good
		else if (mclk_q && !boot_mode_clock_in)
			idx <= idx + 1;
	end
	// One bit stands for a whole mode clock period
	assign boot_mode_data_out = stream_in[idx[4:0]];
endmodule

// *** verif/cpu_system_and_init_interface_bench.sv ***
// Self-checking bench for the system and init interface block
module cpu_system_and_init_interface_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LEN = 32; // Shortened boot stream
	// Inputs
	logic clk_in = 0, rstn_in = 0, primary_clock_in = 0;
	logic cold_reset_n_in = 0, reset_n_in = 0, power_good_in = 0;
	logic [5:0] int_n_in = '1;
	logic nmi_n_in = 1, ext_request_n_in = 1, read_accept_n_in = 1;
	logic write_accept_n_in = 1, agent_valid_n_in = 1;
	logic [63:0] addr_data_bus_in = '0;
	logic [7:0] addr_data_check_bus_in = '0;
	logic [8:0] command_id_bus_in = '0;
	logic command_parity_bit_in = 1, tx_valid_in = 0, tx_is_read_in = 0;
	logic tx_is_write_in = 0, release_req_in = 0, reclaim_in = 0;
	logic timer_irq_in = 0;
	csi_pkg::csi_word_t tx_word_in = '0;
	wire logic boot_mode_data_in;
	// Outputs
	logic primary_clock_out, system_clock_out, sync_loop_out;
	logic boot_mode_clock_out, reserved_future_output_out, fault_n_out;
	logic release_n_out, cpu_valid_n_out, addr_data_bus_oe_out;
	logic addr_data_check_bus_oe_out, command_id_bus_oe_out;
	logic command_parity_bit_out, command_parity_bit_oe_out, tx_ready_out;
	logic ext_request_out, rx_valid_out, core_reset_out, boot_done_out;
	logic [1:0] transmit_clock_out, receive_clock_out;
	logic [63:0] addr_data_bus_out;
	logic [7:0] addr_data_check_bus_out;
	logic [8:0] command_id_bus_out;
	logic [6:0] irq_out;
	csi_pkg::csi_word_t rx_word_out;
	csi_pkg::csi_boot_cfg_t boot_cfg_out;
	// Bench state
	int fail_count = 0, checks = 0, n, r1, r2, b;
	logic [31:0] seed = 32'h67b1341b, r, stream = '0;
	logic mc, s0;
	logic [1:0] tc;
	logic [2:0] pq; // Master pin history, newest in bit 0
	csi_pkg::csi_word_t w;

	// Clocks: core at 10 MHz, master pin slower and unrelated
	always #50 clk_in = ~clk_in;
	// Master pin moves every 440 ns, landing on a core edge every fifth move
	always #440 primary_clock_in = ~primary_clock_in;
	// Master pin as the core clock saw it, for the echo check
	always @(posedge clk_in) pq <= {pq[1:0], primary_clock_in};

	csi_top #(.MODE_LEN(LEN)) dut (.clk_in, .rstn_in, .primary_clock_in,
		.cold_reset_n_in, .reset_n_in, .power_good_in, .boot_mode_data_in,
		.primary_clock_out, .system_clock_out, .sync_loop_out,
		.transmit_clock_out, .receive_clock_out, .boot_mode_clock_out,
		.reserved_future_output_out, .fault_n_out, .int_n_in, .nmi_n_in,
		.ext_request_n_in, .read_accept_n_in, .write_accept_n_in,
		.agent_valid_n_in, .release_n_out, .cpu_valid_n_out,
		.addr_data_bus_in, .addr_data_bus_out, .addr_data_bus_oe_out,
		.addr_data_check_bus_in, .addr_data_check_bus_out,
		.addr_data_check_bus_oe_out, .command_id_bus_in,
		.command_id_bus_out, .command_id_bus_oe_out, .command_parity_bit_in,
		.command_parity_bit_out, .command_parity_bit_oe_out, .tx_valid_in,
		.tx_is_read_in, .tx_is_write_in, .tx_word_in, .tx_ready_out,
		.release_req_in, .reclaim_in, .ext_request_out, .rx_valid_out,
		.rx_word_out, .timer_irq_in, .irq_out, .core_reset_out,
		.boot_done_out, .boot_cfg_out);

	csi_agent agent (.clk_in, .power_good_in,
		.boot_mode_clock_in(boot_mode_clock_out), .stream_in(stream),
		.boot_mode_data_out(boot_mode_data_in));

	// ****************************************
	// Helpers
	// ****************************************
	// Xorshift source of stimulus
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Even parity of each byte
	function logic [7:0] par(logic [63:0] d);
		for (int i = 0; i < 8; i++)
			par[i] = ^d[8*i+:8];
	endfunction
	// Configuration expected from a stream
	function csi_pkg::csi_boot_cfg_t cfg(logic [31:0] s);
		return {s[4:1], s[7:5], s[8], s[10:9], s[11], s[14:13], s[16:15],
			s[18:17]};
	endfunction
	// Step to just after the next rising edge
	task tick(int k = 1);
		repeat (k) @(posedge clk_in);
		#1;
	endtask
	// Count a comparison and report a miss
	task chk(logic ok, string m);
		checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	// A wait that ran out ends the run
	task limit(int k, int lim);
		if (k >= lim) begin
			chk(1'b0, "wait ran out");
			final_report();
		end
	endtask
	// Counts and verdict
	task final_report();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		tick(20);
		rstn_in = 1;
		tick(4);
		chk(core_reset_out === 1'b1, "core reset");
		chk(system_clock_out === 1'b0, "clock ran in cold reset");
		cold_reset_n_in = 1;
		reset_n_in = 1;
		// Reserved input has no pin here; the board ties it high
		for (n = 0; n < 10 && core_reset_out !== 1'b0; n++) tick();
		limit(n, 10);
		// Clocks toggle at system rate in identical pairs
		for (n = 0; n < 4; n++) begin
			s0 = system_clock_out;
			tc = transmit_clock_out;
			tick();
			chk(system_clock_out === ~s0, "sclk");
			chk(sync_loop_out === system_clock_out, "sync out");
			chk(transmit_clock_out === ~tc && ^tc === 1'b0, "tclk");
			chk(^receive_clock_out === 1'b0, "rclk pair");
			chk(primary_clock_out === pq[2], "master echo");
		end
		chk(fault_n_out === 1'b1, "fault");
		chk(reserved_future_output_out === 1'b1, "reserved out");
		chk(command_parity_bit_out === 1'b0, "cmd parity");
		// Interrupts, corners first then random
		for (n = 0; n < 6; n++) begin
			r = (n == 0) ? '0 : (n == 1) ? '1 : rnd();
			int_n_in = r[5:0];
			nmi_n_in = r[6];
			timer_irq_in = r[7];
			tick(4);
			chk(irq_out === ({~nmi_n_in, ~int_n_in} |
				{1'h0, timer_irq_in, 5'h00}), "irq");
		end
		// Read refused while the agent is not read-ready
		tx_valid_in = 1;
		tx_is_read_in = 1;
		tick(3);
		chk(tx_ready_out === 1'b0, "read taken");
		tx_is_read_in = 0;
		tx_is_write_in = 1;
		tick();
		chk(tx_ready_out === 1'b0, "write taken");
		write_accept_n_in = 0;
		read_accept_n_in = 0;
		// Writes and reads in turn with random words
		for (b = 0; b < 4; b++) begin
			tx_is_read_in = b[0];
			tx_is_write_in = !b[0];
			r = rnd();
			tx_word_in = {rnd(), rnd(), 8'h00, r[8:0]};
			for (n = 0; n < 10 && tx_ready_out !== 1'b1; n++) tick();
			limit(n, 10);
			tick();
			tx_valid_in = 0;
			chk(cpu_valid_n_out === 1'b0, "no strobe");
			chk(addr_data_bus_out === tx_word_in.ad, "ad out");
			chk(addr_data_check_bus_out === par(tx_word_in.ad), "par");
			chk(command_id_bus_out === tx_word_in.cmd, "cmd out");
			chk({addr_data_bus_oe_out, addr_data_check_bus_oe_out,
				command_id_bus_oe_out, command_parity_bit_oe_out} === 4'hf, "oe");
			tick();
			chk(cpu_valid_n_out === 1'b1, "strobe held");
			tx_valid_in = 1;
		end
		tx_valid_in = 0;
		// Handover to slave state
		release_req_in = 1;
		tick();
		release_req_in = 0;
		chk(release_n_out === 1'b0, "no release");
		chk({addr_data_bus_oe_out, addr_data_check_bus_oe_out,
			command_id_bus_oe_out, command_parity_bit_oe_out} === 4'h0, "oe slave");
		tick();
		chk(release_n_out === 1'b1, "release held");
		// Agent drives one word, then lines show its inverse
		r = rnd();
		w = {rnd(), rnd(), 8'h00, r[8:0]};
		{addr_data_bus_in, command_id_bus_in} = {w.ad, w.cmd};
		addr_data_check_bus_in = par(w.ad);
		agent_valid_n_in = 0;
		tick();
		agent_valid_n_in = 1;
		{addr_data_bus_in, command_id_bus_in} = ~{w.ad, w.cmd};
		for (n = 0; n < 6 && rx_valid_out !== 1'b1; n++) tick();
		limit(n, 6);
		chk(rx_word_out.ad === w.ad && rx_word_out.cmd === w.cmd, "rx");
		chk(rx_word_out.check === par(w.ad), "rx check");
		ext_request_n_in = 0;
		tick(3);
		chk(ext_request_out === 1'b1, "ext request");
		ext_request_n_in = 1;
		reclaim_in = 1;
		tick();
		reclaim_in = 0;
		tick();
		chk(addr_data_bus_oe_out === 1'b1, "reclaim");
		// Boot streams: random, then every used bit set
		for (b = 0; b < 2; b++) begin
			stream = (b == 0) ? (rnd() & 32'h0007effe) : 32'h0007effe;
			int_n_in = '1;
			timer_irq_in = 1;
			power_good_in = 1;
			{r1, r2, mc} = '0;
			for (n = 0; n < LEN * 512 + 600 && boot_done_out !== 1'b1;
				n++) begin
				tick();
				if (boot_mode_clock_out === 1'b1 && !mc)
					if (r1 == 0) r1 = n;
					else if (r2 == 0) r2 = n;
				mc = boot_mode_clock_out;
			end
			limit(n, LEN * 512 + 600);
			chk(r2 - r1 == 512, "mode clock period");
			chk(boot_cfg_out === cfg(stream), "cfg");
			power_good_in = 0;
			tick(6);
			chk(irq_out[5] === ~stream[11], "timer gate");
			chk((transmit_clock_out & stream[16:15]) === 2'h0, "tx");
			chk((receive_clock_out & stream[18:17]) === 2'h0, "rx");
		end
		final_report();
	end
endmodule
